// ### include/etc_pkg.sv
// Shared constants, modes and carriers for the exposure and trigger control block
package etc_pkg;

  // Clock rate and time bases
  localparam int unsigned CLK_MHZ       = 200;
  localparam int unsigned US_STEP_US    = 1;
  localparam int unsigned US_CYCLES     = US_STEP_US * CLK_MHZ;
  localparam int unsigned EXP_MAX_US    = 10_000_000;
  localparam int unsigned EXP_MIN_US_DF = 10;

  // Field widths
  localparam int unsigned US_W    = 24;
  localparam int unsigned CYC_W   = 32;
  localparam int unsigned GAIN_W  = 16;
  localparam int unsigned ROWS_W  = 12;
  localparam int unsigned ROWT_W  = 8;
  localparam int unsigned DARK_W  = 8;
  localparam int unsigned POST_SH = 8;

  // Values after reset, and the dark offset ceiling
  localparam logic [GAIN_W-1:0] GAIN_ANALOG_RST  = 16'h0064;
  localparam logic [GAIN_W-1:0] GAIN_SDIG_RST    = 16'h000a;
  localparam logic [GAIN_W-1:0] GAIN_POST_RST    = 16'h0100;
  localparam logic [DARK_W-1:0] DARK_RST         = 8'h00;
  localparam logic [DARK_W-1:0] DARK_MAX         = 8'hff;

  // How exposure is tied to sensor timing
  typedef enum logic {
    ETC_SCHEME_SYNC,
    ETC_SCHEME_RESET
  } etc_sync_scheme_t;

  // Where exposure length comes from
  typedef enum logic {
    ETC_LEN_TIMED,
    ETC_LEN_PULSE_WIDTH
  } etc_len_src_t;

  // Gain stage that a write lands in
  typedef enum logic [1:0] {
    ETC_STAGE_SENS_ANALOG,
    ETC_STAGE_SENS_DIGITAL,
    ETC_STAGE_POST_SENSOR
  } etc_stage_t;

  typedef enum {
    EXP_IDLE,
    EXP_WAIT,
    EXP_RUN,
    EXP_HOLD
  } etc_exp_state_t;

  typedef enum {
    RD_IDLE,
    RD_RUN
  } etc_rd_state_t;

  // Gain write command
  typedef struct packed {
    logic              write;
    etc_stage_t        stage;
    logic [GAIN_W-1:0] value;
  } etc_gain_cmd_t;

  // Sensor row timing description
  typedef struct packed {
    logic [ROWS_W-1:0] rows;
    logic [ROWT_W-1:0] blank_cycles;
    logic [ROWT_W-1:0] read_cycles;
  } etc_row_timing_t;

endpackage

// ### verilog/etc_exposure_ctrl.sv
// Exposure, trigger alignment, readout sequencing and gain holding for one sensor
`timescale 1ns/1ps
module etc_exposure_ctrl
  import etc_pkg::*;
#(
  parameter int unsigned PIX_W      = 12,
  parameter int unsigned EXP_MIN_US = EXP_MIN_US_DF
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire etc_sync_scheme_t      exposure_sync_scheme,
  input  wire etc_len_src_t          exposure_length_source,
  input  wire logic                  hardware_trigger_switch,
  input  wire logic                  parallel_row_blanking,
  input  wire logic                  timer_trigger,
  input  wire logic                  trigger_line,
  input  wire logic                  software_trigger,
  input  wire logic [US_W-1:0]       exposure_time_us,
  input  wire etc_row_timing_t       row_timing,
  input  wire etc_gain_cmd_t         gain_cmd,
  input  wire logic [15:0]           dark_offset_value,
  input  wire logic [PIX_W-1:0]      pixel_in,
  input  wire logic                  pixel_in_valid,
  output logic                       sensor_timing_reset,
  output logic                       exposure_active,
  output logic                       readout_active,
  output logic                       row_blank_active,
  output logic                       row_read_active,
  output logic                       invalid_frame_trigger,
  output logic [US_W-1:0]            achieved_integration_time,
  output logic [GAIN_W-1:0]          analog_gain_reg,
  output logic [GAIN_W-1:0]          sensor_digital_gain_reg,
  output logic [GAIN_W-1:0]          post_sensor_amplification,
  output logic [DARK_W-1:0]          dark_offset_reg,
  output logic [PIX_W-1:0]           pixel_out,
  output logic                       pixel_out_valid
);

  // Clamp a requested duration into the legal span
  function automatic logic [US_W-1:0] clamp_us(input logic [US_W-1:0] req);
    logic [US_W-1:0] lo;
    logic [US_W-1:0] hi;
    lo = US_W'(EXP_MIN_US);
    hi = US_W'(EXP_MAX_US);
    if (req < lo) begin
      clamp_us = lo;
    end else if (req > hi) begin
      clamp_us = hi;
    end else begin
      clamp_us = req;
    end
  endfunction

  // Larger of two row phase lengths
  function automatic logic [ROWT_W:0] max_len(input logic [ROWT_W-1:0] a,
                                              input logic [ROWT_W-1:0] b);
    max_len = (a > b) ? {1'b0, a} : {1'b0, b};
  endfunction

  // Sequencer state, counters and trigger edge memory
  etc_exp_state_t       exp_state_reg;
  etc_exp_state_t       exp_state_next;
  etc_rd_state_t        rd_state_reg;
  logic [CYC_W-1:0]     exp_cyc_reg;
  logic [CYC_W-1:0]     exp_left_reg;
  logic [CYC_W-1:0]     rd_left_reg;
  logic [ROWS_W-1:0]    row_cnt_reg;
  logic [ROWT_W:0]      phase_cnt_reg;
  logic [7:0]           us_div_reg;
  logic [US_W-1:0]      us_acc_reg;
  logic                 line_prev_reg;
  logic                 pulse_mode_reg;

  // Trigger sources; free-run timer stands in while the line is off
  wire line_rise   = trigger_line && !line_prev_reg;
  wire trig_pulse  = software_trigger ||
                     (hardware_trigger_switch ? line_rise : timer_trigger);
  wire pw_sel      = (exposure_length_source == ETC_LEN_PULSE_WIDTH) &&
                     hardware_trigger_switch;
  wire is_reset    = (exposure_sync_scheme == ETC_SCHEME_RESET);
  wire rd_busy     = (rd_state_reg == RD_RUN);
  wire exp_idle    = (exp_state_reg == EXP_IDLE);

  // Acceptance: sync needs only this frame's readout started, reset needs all idle
  wire accept_sync = !is_reset && exp_idle;
  wire accept_rst  = is_reset && exp_idle && !rd_busy;
  wire accepted    = trig_pulse && (accept_sync || accept_rst);
  wire early_trig  = trig_pulse && !is_reset && !exp_idle;

  // Exposure length in cycles from microsecond steps
  wire [US_W-1:0]  exp_us_clamped = clamp_us(exposure_time_us);
  wire [CYC_W-1:0] exp_cyc_new    = CYC_W'(exp_us_clamped) * CYC_W'(US_CYCLES);

  // Delay start only when a timed exposure would finish before the readout
  // Pulse-width exposures never wait; their length is unknown ahead
  wire need_delay  = !is_reset && !pw_sel && rd_busy &&
                     (rd_left_reg > exp_cyc_new);
  wire wait_done   = (rd_left_reg <= exp_cyc_reg) || !rd_busy;

  // End of exposure: pulse falls or timer runs out, with a ten second cap
  wire pw_end      = pulse_mode_reg && (!trigger_line ||
                     (us_acc_reg >= US_W'(EXP_MAX_US)));
  wire timed_end   = !pulse_mode_reg && (exp_left_reg <= 32'h0000_0001);
  wire exp_end     = (exp_state_reg == EXP_RUN) && (pw_end || timed_end);
  wire start_rd    = (exp_end && !rd_busy) ||
                     ((exp_state_reg == EXP_HOLD) && !rd_busy);
  wire us_tick     = (us_div_reg == 8'(US_CYCLES - 1));

  // Row period: sequential sums the phases, fast mode overlaps them
  wire [ROWT_W:0]  row_seq   = {1'b0, row_timing.blank_cycles} +
                               {1'b0, row_timing.read_cycles};
  wire [ROWT_W:0]  row_par   = max_len(row_timing.blank_cycles, row_timing.read_cycles);
  wire [ROWT_W:0]  row_len   = parallel_row_blanking ? row_par : row_seq;
  wire [CYC_W-1:0] frame_len = CYC_W'(row_timing.rows) * CYC_W'(row_len);
  wire             row_last  = (phase_cnt_reg >= (row_len - 9'h001));
  wire             blank_now = parallel_row_blanking ?
                               (phase_cnt_reg < {1'b0, row_timing.blank_cycles}) :
                               (phase_cnt_reg < {1'b0, row_timing.blank_cycles});
  wire             read_now  = parallel_row_blanking ?
                               (phase_cnt_reg < {1'b0, row_timing.read_cycles}) :
                               !blank_now;

  // Exposure state sequencing
  always_comb begin
    exp_state_next = exp_state_reg;
    case (exp_state_reg)
      EXP_IDLE: begin
        if (accepted) begin
          exp_state_next = need_delay ? EXP_WAIT : EXP_RUN;
        end
      end
      EXP_WAIT: begin
        if (wait_done) begin
          exp_state_next = EXP_RUN;
        end
      end
      EXP_RUN: begin
        if (exp_end) begin
          exp_state_next = rd_busy ? EXP_HOLD : EXP_IDLE;
        end
      end
      EXP_HOLD: begin
        if (!rd_busy) begin
          exp_state_next = EXP_IDLE;
        end
      end
      default: begin
        exp_state_next = EXP_IDLE;
      end
    endcase
  end

  // Exposure state, length and microsecond divider
  always_ff @(posedge clock) begin
    if (rst) begin
      exp_state_reg  <= EXP_IDLE;
      exp_cyc_reg    <= '0;
      exp_left_reg   <= '0;
      us_div_reg     <= 8'h00;
      line_prev_reg  <= 1'b0;
      pulse_mode_reg <= 1'b0;
    end else if (ce) begin
      exp_state_reg <= exp_state_next;
      line_prev_reg <= trigger_line;
      // Divider free-runs, so achieved time is good to one microsecond
      us_div_reg    <= us_tick ? 8'h00 : us_div_reg + 8'h01;
      if (accepted) begin
        exp_cyc_reg    <= exp_cyc_new;
        exp_left_reg   <= exp_cyc_new;
        pulse_mode_reg <= pw_sel;
      end else if (exp_state_reg == EXP_RUN) begin
        exp_left_reg <= exp_left_reg - 32'h0000_0001;
      end
    end
  end

  // Integration time measured in microseconds, latched at exposure end
  always_ff @(posedge clock) begin
    if (rst) begin
      us_acc_reg                <= '0;
      achieved_integration_time <= '0;
    end else if (ce) begin
      if (exp_state_next == EXP_RUN && exp_state_reg != EXP_RUN) begin
        us_acc_reg <= '0;
      end else if (exp_state_reg == EXP_RUN && us_tick) begin
        us_acc_reg <= us_acc_reg + 24'h00_0001;
      end
      if (exp_end) begin
        achieved_integration_time <= us_acc_reg;
      end
    end
  end

  // Readout row sequencer
  // Zero rows leaves the sequencer idle instead of wrapping the count
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_state_reg  <= RD_IDLE;
      rd_left_reg   <= '0;
      row_cnt_reg   <= '0;
      phase_cnt_reg <= '0;
    end else if (ce) begin
      if (start_rd && frame_len != '0) begin
        rd_state_reg  <= RD_RUN;
        rd_left_reg   <= frame_len;
        row_cnt_reg   <= '0;
        phase_cnt_reg <= '0;
      end else if (rd_busy) begin
        rd_left_reg <= rd_left_reg - 32'h0000_0001;
        if (row_last) begin
          phase_cnt_reg <= '0;
          row_cnt_reg   <= row_cnt_reg + 12'h001;
        end else begin
          phase_cnt_reg <= phase_cnt_reg + 9'h001;
        end
        if (rd_left_reg <= 32'h0000_0001) begin
          rd_state_reg <= RD_IDLE;
        end
      end
    end
  end

  // Status pins registered for clean outputs
  // They trail internal state by one cycle, which users must allow for
  always_ff @(posedge clock) begin
    if (rst) begin
      sensor_timing_reset   <= 1'b0;
      exposure_active       <= 1'b0;
      readout_active        <= 1'b0;
      row_blank_active      <= 1'b0;
      row_read_active       <= 1'b0;
      invalid_frame_trigger <= 1'b0;
    end else if (ce) begin
      sensor_timing_reset   <= accepted && is_reset;
      exposure_active       <= (exp_state_reg == EXP_RUN);
      readout_active        <= rd_busy;
      row_blank_active      <= rd_busy && blank_now;
      row_read_active       <= rd_busy && read_now;
      invalid_frame_trigger <= early_trig;
    end else begin
      // A frozen cycle must not stretch the event pulse
      invalid_frame_trigger <= 1'b0;
      sensor_timing_reset   <= 1'b0;
    end
  end

  // Gain stages and dark offset; each write touches one stage only
  always_ff @(posedge clock) begin
    if (rst) begin
      analog_gain_reg           <= GAIN_ANALOG_RST;
      sensor_digital_gain_reg   <= GAIN_SDIG_RST;
      post_sensor_amplification <= GAIN_POST_RST;
      dark_offset_reg           <= DARK_RST;
    end else if (ce) begin
      if (gain_cmd.write && gain_cmd.stage == ETC_STAGE_SENS_ANALOG) begin
        analog_gain_reg <= gain_cmd.value;
      end
      if (gain_cmd.write && gain_cmd.stage == ETC_STAGE_SENS_DIGITAL) begin
        sensor_digital_gain_reg <= gain_cmd.value;
      end
      if (gain_cmd.write && gain_cmd.stage == ETC_STAGE_POST_SENSOR) begin
        post_sensor_amplification <= gain_cmd.value;
      end
      dark_offset_reg <= (dark_offset_value > 16'(DARK_MAX)) ?
                         DARK_MAX : dark_offset_value[DARK_W-1:0];
    end
  end

  // Post-sensor gain, fixed point with 8 fraction bits, saturating
  localparam int unsigned PROD_W = PIX_W + GAIN_W;
  wire [PROD_W-1:0] pix_prod   = PROD_W'(pixel_in) * PROD_W'(post_sensor_amplification);
  wire [PROD_W-1:0] pix_scaled = pix_prod >> POST_SH;
  wire              pix_over   = |pix_scaled[PROD_W-1:PIX_W];

  // Pixel register; valid is delayed by the same one cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      pixel_out       <= '0;
      pixel_out_valid <= 1'b0;
    end else if (ce) begin
      pixel_out       <= pix_over ? {PIX_W{1'b1}} : pix_scaled[PIX_W-1:0];
      pixel_out_valid <= pixel_in_valid;
    end
  end

endmodule

// ### dv/etc_exposure_ctrl_asserts.sv
// Port-level checks for the exposure and trigger control block
`timescale 1ns/1ps
module etc_exposure_ctrl_asserts
  import etc_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              ce,
  input wire etc_sync_scheme_t  exposure_sync_scheme,
  input wire logic              parallel_row_blanking,
  input wire etc_row_timing_t   row_timing,
  input wire etc_gain_cmd_t     gain_cmd,
  input wire logic [15:0]       dark_offset_value,
  input wire logic              pixel_in_valid,
  input wire logic              sensor_timing_reset,
  input wire logic              exposure_active,
  input wire logic              readout_active,
  input wire logic              row_blank_active,
  input wire logic              row_read_active,
  input wire logic              invalid_frame_trigger,
  input wire logic [GAIN_W-1:0] analog_gain_reg,
  input wire logic [GAIN_W-1:0] sensor_digital_gain_reg,
  input wire logic [GAIN_W-1:0] post_sensor_amplification,
  input wire logic [DARK_W-1:0] dark_offset_reg,
  input wire logic              pixel_out_valid
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire rs = (exposure_sync_scheme == ETC_SCHEME_RESET);
  a_invalid_one_cycle: assert property (
    invalid_frame_trigger |=> !invalid_frame_trigger)
    else $error("invalid trigger pulse too long");
  a_reset_no_flag: assert property (
    rs && $stable(rs) |-> !invalid_frame_trigger)
    else $error("flag raised in reset scheme");
  a_str_then_expose: assert property (
    sensor_timing_reset |=> exposure_active && !sensor_timing_reset)
    else $error("timing reset not followed by exposure");
  a_str_scheme: assert property (
    sensor_timing_reset |-> rs)
    else $error("timing reset in sync scheme");
  a_reset_sequential: assert property (
    rs && $stable(rs) |-> !(exposure_active && readout_active))
    else $error("overlap in reset scheme");
  a_read_after_exp: assert property (
    $fell(exposure_active) && rs && row_timing.rows != 12'h000 |-> ##[0:3] readout_active)
    else $error("readout did not follow exposure");
  a_parallel_phases: assert property (
    row_blank_active && row_read_active |-> parallel_row_blanking)
    else $error("row phases overlap in normal readout");
  a_gain_analog: assert property (
    ce && gain_cmd.write && gain_cmd.stage == ETC_STAGE_SENS_ANALOG |=>
    analog_gain_reg == $past(gain_cmd.value) && $stable(sensor_digital_gain_reg) &&
    $stable(post_sensor_amplification))
    else $error("analog gain write wrong");
  a_gain_post: assert property (
    ce && gain_cmd.write && gain_cmd.stage == ETC_STAGE_POST_SENSOR |=>
    post_sensor_amplification == $past(gain_cmd.value) && $stable(analog_gain_reg) &&
    $stable(sensor_digital_gain_reg))
    else $error("post gain write wrong");
  a_dark_clamp: assert property (
    ce |=> dark_offset_reg ==
    ($past(dark_offset_value) > 16'h00ff ? DARK_MAX : 8'($past(dark_offset_value))))
    else $error("dark offset not clamped");
  a_pixel_valid: assert property (
    ce && pixel_in_valid |=> pixel_out_valid)
    else $error("pixel valid lost");
endmodule
bind etc_exposure_ctrl etc_exposure_ctrl_asserts u_chk (.clock, .rst, .ce, .exposure_sync_scheme,
  .parallel_row_blanking, .row_timing, .gain_cmd, .dark_offset_value, .pixel_in_valid,
  .sensor_timing_reset, .exposure_active, .readout_active, .row_blank_active, .row_read_active,
  .invalid_frame_trigger, .analog_gain_reg, .sensor_digital_gain_reg, .post_sensor_amplification,
  .dark_offset_reg, .pixel_out_valid);

// ### dv/etc_trig_source.sv
// Trigger source model driving the hardware trigger line
`timescale 1ns/1ps
module etc_trig_source (
  input  wire logic        clock,
  input  wire logic        fire,
  input  wire logic [15:0] width,
  output logic             trigger_line
);
  int left = 0;
  // Idle low; held high for the commanded width in cycles
  always @(posedge clock) begin
    if (fire) begin
      left <= width;
    end else if (left > 0) begin
      left <= left - 1;
    end
  end
  assign trigger_line = (left > 0);
endmodule

// ### dv/testbench.sv
// Self-checking bench for the exposure and trigger control block
`timescale 1ns/1ps
module testbench;
  import etc_pkg::*;
  typedef struct {etc_stage_t st; logic [15:0] v; logic [11:0] px; logic [11:0] po;} etc_row_t;
  logic clock = 0, rst = 1, ce = 1, timer_trigger = 0, software_trigger = 0, fire = 0;
  logic hardware_trigger_switch = 0, parallel_row_blanking = 0, pixel_in_valid = 0;
  etc_sync_scheme_t exposure_sync_scheme = ETC_SCHEME_RESET;
  etc_len_src_t     exposure_length_source = ETC_LEN_TIMED;
  logic [US_W-1:0]  exposure_time_us = 24'h00000a;
  etc_row_timing_t  row_timing = '{12'h004, 8'h0a, 8'h14};
  etc_gain_cmd_t    gain_cmd = '0;
  logic [15:0]      dark_offset_value = 16'h0000;
  logic [11:0]      pixel_in = 12'h000;
  logic [11:0]      pixel_out;
  logic trigger_line, sensor_timing_reset, exposure_active, readout_active, pixel_out_valid;
  logic row_blank_active, row_read_active, invalid_frame_trigger, pe = 0, pr = 0;
  logic [US_W-1:0]   achieved_integration_time;
  logic [GAIN_W-1:0] analog_gain_reg, sensor_digital_gain_reg, post_sensor_amplification;
  logic [GAIN_W-1:0] ma = GAIN_ANALOG_RST, md = GAIN_SDIG_RST, mp = GAIN_POST_RST;
  logic [DARK_W-1:0] dark_offset_reg;
  int err_total = 0, n_checks = 0, cyc = 0, n_er = 0, n_rr = 0, n_rf = 0, n_inv = 0, n_str = 0;
  int t_er, t_ef, t_rr, t_rf;
  // Gain rows; expected pixel is saturated (pixel * post) / 256
  etc_row_t rows [5] = '{'{ETC_STAGE_SENS_ANALOG, 16'h00c8, 12'h123, 12'h123},
    '{ETC_STAGE_SENS_DIGITAL, 16'h0014, 12'h7ff, 12'h7ff},
    '{ETC_STAGE_POST_SENSOR, 16'h0200, 12'h400, 12'h800},
    '{ETC_STAGE_POST_SENSOR, 16'h0200, 12'hfff, 12'hfff},
    '{ETC_STAGE_POST_SENSOR, 16'h0080, 12'h0ff, 12'h07f}};
  // Reset-scheme frames: microseconds, fast readout, readout cycles of 4 rows of 10+20
  int fr [2][3] = '{'{3, 0, 120}, '{11, 1, 80}};
  etc_exposure_ctrl u_dut (.clock, .rst, .ce, .exposure_sync_scheme, .exposure_length_source,
    .hardware_trigger_switch, .parallel_row_blanking, .timer_trigger, .trigger_line,
    .software_trigger, .exposure_time_us, .row_timing, .gain_cmd, .dark_offset_value, .pixel_in,
    .pixel_in_valid, .sensor_timing_reset, .exposure_active, .readout_active, .row_blank_active,
    .row_read_active, .invalid_frame_trigger, .achieved_integration_time, .analog_gain_reg,
    .sensor_digital_gain_reg, .post_sensor_amplification, .dark_offset_reg, .pixel_out,
    .pixel_out_valid);
  etc_trig_source u_src (.clock, .fire, .width(16'h01f4), .trigger_line);
  always #2.5 clock = ~clock;
  // Edge times and event counts; held clear in reset so unknown outputs cannot poison them
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (rst) begin
      pe <= 1'b0;
      pr <= 1'b0;
    end else begin
      pe <= exposure_active;
      pr <= readout_active;
      if (exposure_active && !pe) begin
        t_er <= cyc;
      end
      if (!exposure_active && pe) begin
        t_ef <= cyc;
      end
      if (readout_active && !pr) begin
        t_rr <= cyc;
      end
      if (!readout_active && pr) begin
        t_rf <= cyc;
      end
      n_er <= n_er + (exposure_active && !pe);
      n_rr <= n_rr + (readout_active && !pr);
      n_rf <= n_rf + (!readout_active && pr);
      n_inv <= n_inv + invalid_frame_trigger;
      n_str <= n_str + sensor_timing_reset;
    end
  end
  task end_of_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] want);
    n_checks++;
    if (seen !== want) begin
      err_total++;
      $display("Error at %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  // Cycle figures carry a few cycles of pipeline slack
  task near(input logic [31:0] d, input logic [31:0] w);
    chk(32'(d + 4 >= w && d <= w + 4), 32'h1);
  endtask
  task tk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task sw_pulse();
    software_trigger = 1;
    tk(1);
    software_trigger = 0;
  endtask
  // Bounded wait on the count of readout starts or ends
  task wait_cnt(input bit rise, input int k);
    for (int i = 0; i < 40000 && (rise ? n_rr : n_rf) < k; i++) tk(1);
    if ((rise ? n_rr : n_rf) < k) begin
      err_total++;
      end_of_test();
    end
  endtask
  initial begin
    int e, k, a;
    tk(12);
    rst = 0;
    chk(analog_gain_reg, GAIN_ANALOG_RST);
    chk(sensor_digital_gain_reg, GAIN_SDIG_RST);
    chk(post_sensor_amplification, GAIN_POST_RST);
    chk(achieved_integration_time, 24'h000000);
    foreach (rows[i]) begin
      gain_cmd = '{1'b1, rows[i].st, rows[i].v};
      tk(1);
      gain_cmd.write = 0;
      pixel_in = rows[i].px;
      pixel_in_valid = 1;
      if (rows[i].st == ETC_STAGE_SENS_ANALOG) ma = rows[i].v;
      if (rows[i].st == ETC_STAGE_SENS_DIGITAL) md = rows[i].v;
      if (rows[i].st == ETC_STAGE_POST_SENSOR) mp = rows[i].v;
      tk(1);
      chk(analog_gain_reg, ma);
      chk(sensor_digital_gain_reg, md);
      chk(post_sensor_amplification, mp);
      chk(pixel_out, rows[i].po);
    end
    pixel_in_valid = 0;
    dark_offset_value = 16'h0123;
    tk(2);
    chk({pixel_out_valid, dark_offset_reg}, {1'b0, DARK_MAX});
    dark_offset_value = 16'h0042;
    tk(2);
    chk(dark_offset_reg, 8'h42);
    // Frozen clock enable: a gain write must not land
    ce = 0;
    gain_cmd = '{1'b1, ETC_STAGE_SENS_ANALOG, 16'h0001};
    tk(2);
    chk(analog_gain_reg, ma);
    gain_cmd.write = 0;
    ce = 1;
    for (int i = 0; i < 2; i++) begin
      exposure_time_us = fr[i][0];
      parallel_row_blanking = fr[i][1];
      e = fr[i][0] < EXP_MIN_US_DF ? EXP_MIN_US_DF : fr[i][0];
      k = n_str;
      sw_pulse();
      tk(20);
      sw_pulse(); // Arrives mid-exposure and must be dropped
      wait_cnt(0, i + 1);
      tk(3);
      near(t_ef - t_er, e * US_CYCLES);
      near(t_rf - t_rr, fr[i][2]);
      chk(t_rr, t_ef);
      chk(n_str - k, 1);
      a = achieved_integration_time;
      chk(32'(a + 1 >= e && a <= e + 1), 1);
    end
    hardware_trigger_switch = 1;
    exposure_length_source = ETC_LEN_PULSE_WIDTH;
    fire = 1;
    tk(1);
    fire = 0;
    wait_cnt(0, 3);
    tk(3);
    near(t_ef - t_er, 16'h01f4);
    timer_trigger = 1;
    tk(1);
    timer_trigger = 0;
    tk(40);
    chk(n_er, 3);
    hardware_trigger_switch = 0;
    timer_trigger = 1;
    tk(1);
    timer_trigger = 0;
    wait_cnt(0, 4);
    chk({n_er, n_inv}, {32'd4, 32'd0});
    // Sync scheme: long readout of 60 rows of 50+200 cycles against a 10 us exposure
    exposure_sync_scheme = ETC_SCHEME_SYNC;
    parallel_row_blanking = 0;
    row_timing = '{12'h03c, 8'h32, 8'hc8};
    exposure_time_us = 24'h00000a;
    sw_pulse();
    tk(30);
    sw_pulse(); // Before readout start, so refused
    wait_cnt(1, 5);
    sw_pulse();
    tk(30);
    sw_pulse(); // Exposure still pending, so refused
    wait_cnt(0, 5);
    k = t_rf;
    wait_cnt(1, 6);
    near(t_ef, k);
    near(t_er, k - 10 * US_CYCLES);
    chk(n_inv, 2);
    end_of_test();
  end
endmodule
